// ==== rtl/xbar_arb_pkg.sv ====
package xbar_arb_pkg;

  // largest master count that the owner field can name
  localparam int MAX_MASTERS = 4;
  localparam int MST_IDX_W = 2;
  // slave port index width; up to eight slave ports
  localparam int SLV_IDX_W = 3;

  // value of the scheme select after reset: fixed priority
  localparam logic SCHEME_FIXED = 1'h0;
  localparam logic SCHEME_ROUND_ROBIN = 1'h1;
  localparam logic SCHEME_RESET = SCHEME_FIXED;

  // owner of every slave port after reset
  localparam logic [MST_IDX_W-1:0] OWNER_RESET = 2'h0;

  // slave port state, gray along parked -> owned -> burst locked
  typedef enum logic [1:0] {
    PORT_PARKED = 2'h0,
    PORT_OWNED = 2'h1,
    PORT_LOCKED = 2'h3
  } port_state_t;

  // one master's address-phase view, as seen by the switch
  typedef struct packed {
    logic req;                     // non-IDLE transfer presented
    logic burst_more;              // beat is not the last of its burst
    logic outstanding;             // earlier access still completing
    logic [SLV_IDX_W-1:0] target;  // slave port addressed now
    logic [SLV_IDX_W-1:0] prev;    // slave port of the outstanding access
  } master_req_t;

  // per slave port result
  typedef struct packed {
    logic idle;                    // switch drives IDLE on this slave bus
    logic [MST_IDX_W-1:0] owner;   // master granted / parked on the port
  } port_grant_t;

endpackage

// ==== rtl/xbar_slave_arbiter.sv ====
`timescale 1ns/100ps
`default_nettype none

module xbar_slave_arbiter #(
  parameter int NUM_MASTERS = 4,
  parameter int NUM_SLAVES = 4,
  // which master port numbers exist; sparse sets are allowed
  parameter logic [NUM_MASTERS-1:0] MASTER_PRESENT = 4'hF
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic arbitration_scheme_select,
  input wire xbar_arb_pkg::master_req_t [NUM_MASTERS-1:0] master_in,
  output xbar_arb_pkg::port_grant_t [NUM_SLAVES-1:0] port_out,
  output logic [NUM_MASTERS-1:0] master_wait
);

  localparam int MW = xbar_arb_pkg::MST_IDX_W;
  localparam int SW = xbar_arb_pkg::SLV_IDX_W;

  // timing in brief: master_in is sampled at every rising edge, the
  // decision for each slave port is registered there, and port_out and
  // master_wait show it for exactly the next cycle
  // a burst locks its port: beats with burst_more set keep the owner,
  // the last beat (or a dropped or moved request) frees it again
  // a master whose earlier access to another port is still outstanding
  // is not eligible anywhere else, which keeps two masters from waiting
  // on each other across ports
  // fixed mode lets a busy high master starve lower ones; that is the
  // price of a simple priority pick, round-robin is the fair choice
  // targets at or beyond NUM_SLAVES have no arbiter here and never stall
  // their master; an outer decoder must answer such accesses
  // absent master numbers are masked by MASTER_PRESENT, so a sparse set
  // behaves as if those masters never request anything
  // every port is decided by the same loop body, so the ports differ
  // only in the slave index that the eligibility test compares against

  // one place for the parked test, used by the idle flag and the stalls
  function automatic logic port_parked(input xbar_arb_pkg::port_state_t st);
    return st == xbar_arb_pkg::PORT_PARKED;
  endfunction

  // highest numbered requester wins in fixed mode
  function automatic logic [MW-1:0] pick_highest(input logic [NUM_MASTERS-1:0] r);
    logic [MW-1:0] w;
    w = '0;
    // later indices overwrite earlier ones, so the top one wins
    for (int i = 0; i < NUM_MASTERS; i++) begin
      if (r[i]) begin
        w = MW'(i);
      end
    end
    return w;
  endfunction

  // first requester strictly after last, wrapping; last itself comes last
  function automatic logic [MW-1:0] pick_next(input logic [NUM_MASTERS-1:0] r,
                                             input logic [MW-1:0] last);
    logic [MW-1:0] w;
    logic found;
    int idx;
    w = last;
    found = 1'b0;
    idx = 0;
    // a full lap is walked, so any value of last is safe
    for (int k = 1; k <= NUM_MASTERS; k++) begin
      idx = (int'(last) + k) % NUM_MASTERS;
      if (!found && r[idx]) begin
        w = MW'(idx);
        found = 1'b1;
      end
    end
    return w;
  endfunction

  logic scheme_r;
  logic scheme_nxt;
  xbar_arb_pkg::port_state_t [NUM_SLAVES-1:0] state_r;
  xbar_arb_pkg::port_state_t [NUM_SLAVES-1:0] state_nxt;
  logic [NUM_SLAVES-1:0][MW-1:0] owner_r;
  logic [NUM_SLAVES-1:0][MW-1:0] owner_nxt;
  logic [NUM_MASTERS-1:0] wait_r;
  logic [NUM_MASTERS-1:0] wait_nxt;
  logic [NUM_SLAVES-1:0] idle_r;
  logic [NUM_SLAVES-1:0] idle_nxt;

  // scheme select held locally so the port has a known mode at reset
  always_comb begin
    scheme_nxt = arbitration_scheme_select;
  end

  // a change of scheme takes one clock, never lands mid-decision
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      scheme_r <= xbar_arb_pkg::SCHEME_RESET;
    end else begin
      scheme_r <= scheme_nxt;
    end
  end

  // per slave port arbitration, evaluated every clock edge
  always_comb begin
    logic [NUM_MASTERS-1:0] reqs;
    logic [MW-1:0] own;
    logic own_req;
    logic own_burst;
    reqs = '0;
    own = '0;
    own_req = 1'b0;
    own_burst = 1'b0;
    state_nxt = state_r;
    owner_nxt = owner_r;
    for (int s = 0; s < NUM_SLAVES; s++) begin
      // eligible requesters for this port
      for (int m = 0; m < NUM_MASTERS; m++) begin
        reqs[m] = MASTER_PRESENT[m] && master_in[m].req
                  && (master_in[m].target == SW'(s))
                  && !(master_in[m].outstanding
                       && master_in[m].prev != SW'(s));
      end
      // the owner's own view: still eligible here, and mid-burst or not
      own = owner_r[s];
      own_req = reqs[own];
      own_burst = own_req && master_in[own].burst_more;
      // a lock never overrides the outstanding-access rule
      if (state_r[s] == xbar_arb_pkg::PORT_LOCKED && own_req) begin
        // mid-burst: nobody may take the port before the last beat
        owner_nxt[s] = own;
        state_nxt[s] = own_burst ? xbar_arb_pkg::PORT_LOCKED
                                 : xbar_arb_pkg::PORT_OWNED;
      end else if (reqs == '0) begin
        // keep last user; round-robin starts its next search after it
        owner_nxt[s] = own;
        state_nxt[s] = xbar_arb_pkg::PORT_PARKED;
      end else begin
        if (scheme_r == xbar_arb_pkg::SCHEME_FIXED) begin
          // parked or not, the top requester takes it; an active lower
          // owner simply is not in reqs once it idles or moves away
          owner_nxt[s] = pick_highest(reqs);
        end else if (own_req && (reqs & ~(NUM_MASTERS'(1) << own)) == '0) begin
          owner_nxt[s] = own;
        end else begin
          // owner gives way at this beat boundary, or at once if quiet
          owner_nxt[s] = pick_next(reqs, own);
        end
        state_nxt[s] = master_in[owner_nxt[s]].burst_more
                       ? xbar_arb_pkg::PORT_LOCKED : xbar_arb_pkg::PORT_OWNED;
      end
    end
  end

  // a requester not granted its target next cycle sees a wait state
  always_comb begin
    logic [SW-1:0] t;
    t = '0;
    wait_nxt = '0;
    // a parked port serves nobody, not even the master parked on it
    for (int m = 0; m < NUM_MASTERS; m++) begin
      t = master_in[m].target;
      if (MASTER_PRESENT[m] && master_in[m].req) begin
        if (int'(t) >= NUM_SLAVES) begin
          wait_nxt[m] = 1'h0; // unmapped port: no owner to wait on
        end else begin
          wait_nxt[m] = (owner_nxt[t] != MW'(m))
                        || port_parked(state_nxt[t]);
        end
      end
    end
  end

  // idle flag registered so the output comes straight from a flip-flop
  always_comb begin
    for (int s = 0; s < NUM_SLAVES; s++) begin
      idle_nxt[s] = port_parked(state_nxt[s]);
    end
  end

  // all state has a constant reset value; no setup needed
  // ports come up parked on master 0, so the first request after
  // release is arbitrated like any other
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      for (int s = 0; s < NUM_SLAVES; s++) begin
        state_r[s] <= xbar_arb_pkg::PORT_PARKED;
        owner_r[s] <= xbar_arb_pkg::OWNER_RESET;
      end
      wait_r <= '0;
      idle_r <= '1;
    end else begin
      state_r <= state_nxt;
      owner_r <= owner_nxt;
      wait_r <= wait_nxt;
      idle_r <= idle_nxt;
    end
  end

  // outputs straight from the registers
  // they change only at a clock edge or when reset is raised
  always_comb begin
    for (int s = 0; s < NUM_SLAVES; s++) begin
      port_out[s].idle = idle_r[s];
      port_out[s].owner = owner_r[s];
    end
    master_wait = wait_r;
  end

endmodule

`default_nettype wire

// ==== test/crossbar_slave_port_arbiter_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module crossbar_slave_port_arbiter_tb;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic sel = 1'h0;
  xbar_arb_pkg::master_req_t [3:0] want = '0;
  xbar_arb_pkg::master_req_t [3:0] mi;
  xbar_arb_pkg::port_grant_t [3:0] po;
  logic [3:0] mw;
  logic [6:0] q[$];
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  master_model bfm (.want(want), .master_in(mi));
  xbar_slave_arbiter uut (.core_clk(clk), .reset(rst), .arbitration_scheme_select(sel),
    .master_in(mi), .port_out(po), .master_wait(mw));
  initial forever #4 clk = ~clk;
  // all to port 0; note is {idle, owner, stalls} one cycle on
  task automatic step(logic [3:0] m, logic [3:0] b, logic [3:0] s, logic [6:0] e);
    for (int i = 0; i < 4; i++)
      want[i] = '{m[i], b[i], s[i], 3'h0, 3'h1};
    @(posedge clk);
    #1 q.push_back(e);
  endtask
  // compare settled outputs with the oldest note
  always @(negedge clk)
    if (q.size() > 0) begin
      n_compared++;
      if ({po[0], mw} !== q[0]) begin
        bad_count++;
        $display("CHECK FAILED port0 exp %h got %h", q[0], {po[0], mw});
      end
      // untargeted ports stay parked on master 0
      n_compared++;
      if ({po[3], po[2], po[1]} !== 9'h124) begin
        bad_count++;
        $display("CHECK FAILED ports1to3 exp %h got %h", 9'h124, {po[3], po[2], po[1]});
      end
      void'(q.pop_front());
    end
  task automatic stop_test;
    $display("compared %0d failed %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // hang guard, far above the 516 cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      stop_test();
    end
  end
  initial begin
    void'($urandom(55203));
    repeat (3) @(posedge clk);
    #1 rst = 1'h0;
    step(4'h0, 4'h0, 4'h0, 7'h40);
    step(4'hA, 4'h0, 4'h0, 7'h32);
    step(4'h2, 4'h0, 4'h0, 7'h10);
    step(4'h0, 4'h0, 4'h0, 7'h50);
    step(4'h9, 4'h0, 4'h8, 7'h08);
    step(4'h1, 4'h1, 4'h0, 7'h00);
    step(4'h5, 4'h1, 4'h0, 7'h04);
    step(4'h4, 4'h0, 4'h0, 7'h20);
    $display("fixed test done");
    sel = 1'h1;
    step(4'h0, 4'h0, 4'h0, 7'h60);
    step(4'hB, 4'h0, 4'h0, 7'h33);
    step(4'hB, 4'h0, 4'h0, 7'h0A);
    step(4'hB, 4'h0, 4'h0, 7'h19);
    step(4'h2, 4'h0, 4'h0, 7'h10);
    $display("rotation test done");
    repeat (500) begin
      @(posedge clk);
      #1 want = 36'({$urandom(), $urandom()});
      sel = 1'($urandom());
    end
    $display("random test done");
    stop_test();
  end
endmodule
`default_nettype wire

// ==== test/master_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module master_model (
  input wire xbar_arb_pkg::master_req_t [3:0] want,
  output wire xbar_arb_pkg::master_req_t [3:0] master_in
);
  // masters launch just after the edge, never on it
  assign #1 master_in = want;
endmodule
`default_nettype wire

// ==== test/xbar_arb_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none
module xbar_arb_asserts (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic arbitration_scheme_select,
  input wire xbar_arb_pkg::master_req_t [3:0] master_in,
  input wire xbar_arb_pkg::port_grant_t [3:0] port_out,
  input wire logic [3:0] master_wait
);
  logic [3:0] el;
  logic [1:0] o, hi, rp;
  logic nb, nb_r, rr_r, fr;
  // port 0 view; a burst anywhere makes the pick unsure, so skip it
  always_comb begin
    o = port_out[0].owner;
    nb = 1'h1;
    hi = 2'h0;
    rp = o;
    for (int i = 0; i < 4; i++) begin
      el[i] = master_in[i].req && master_in[i].target == 3'h0
        && !(master_in[i].outstanding && master_in[i].prev != 3'h0);
      nb = nb && !master_in[i].burst_more;
      if (el[i])
        hi = 2'(i);
    end
    // first eligible after the last owner, owner itself last
    for (int i = 4; i > 0; i--) begin
      if (el[2'(o + i)])
        rp = 2'(o + i);
    end
    fr = nb && nb_r && el != 4'h0;
  end
  // scheme as the arbiter sees it, one cycle late
  always_ff @(posedge core_clk or posedge reset)
    if (reset)
      {rr_r, nb_r} <= 2'h0;
    else
      {rr_r, nb_r} <= {arbitration_scheme_select, nb};
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  a_reset_clear: assert property (
    $fell(reset) |-> port_out[0].idle && o == 2'h0 && master_wait == 4'h0)
    else $error("outputs not clear after reset");
  a_idle_park: assert property (!el |=> port_out[0].idle && $stable(o))
    else $error("port not parked");
  a_fixed_pick: assert property (
    !rr_r && fr |=> o == $past(hi) && !port_out[0].idle)
    else $error("fixed pick wrong");
  a_rr_pick: assert property (rr_r && fr |=> o == $past(rp))
    else $error("rotation pick wrong");
  a_burst_hold: assert property (
    (el[o] && master_in[o].burst_more)
    ##1 (el[o] && master_in[o].burst_more && $stable(o)) |=> $stable(o))
    else $error("owner lost in burst");
  a_owner_ready: assert property (!port_out[0].idle |-> !master_wait[o])
    else $error("owner stalled");
  a_move_wait: assert property (
    master_in[3].req && master_in[3].outstanding && master_in[3].prev != 3'h0
    && master_in[3].target == 3'h0 |=> master_wait[3])
    else $error("mover not stalled");
  a_wait_cause: assert property (master_wait[1] |-> $past(master_in[1].req))
    else $error("stall without request");
endmodule
bind xbar_slave_arbiter xbar_arb_asserts chk (.core_clk(core_clk), .reset(reset),
  .arbitration_scheme_select(arbitration_scheme_select), .master_in(master_in),
  .port_out(port_out), .master_wait(master_wait));
`default_nettype wire
